/* irf_pkg.sv */
// Package for the integer register file: widths, carriers, codes
package irf_pkg;
    localparam int IRF_XLEN = 64;
    localparam int IRF_NREG = 32;
    localparam int IRF_AW = 5;
    localparam int IRF_FLEN = 32;
    localparam logic [IRF_AW-1:0] IRF_ZERO_IDX = 5'h00;
    localparam logic [IRF_XLEN-1:0] IRF_RST_VAL = 64'h0000000000000000;
    localparam logic [IRF_FLEN-1:0] IRF_FRST_VAL = 32'h00000000;
    localparam logic [IRF_FLEN-1:0] IRF_FCSR_RST = 32'h00000000;

    // Read request from decode
    typedef struct packed {
        logic [IRF_AW-1:0] idx;
    } irf_rd_req_t;

    // Forwarding or write-back source
    typedef struct packed {
        logic en;
        logic [IRF_AW-1:0] idx;
        logic [IRF_XLEN-1:0] data;
    } irf_wr_t;

    // Product write from multiply/divide unit
    typedef struct packed {
        logic en;
        logic [IRF_XLEN-1:0] top;
        logic [IRF_XLEN-1:0] bottom;
    } irf_prod_t;

    // Floating-point register access
    typedef struct packed {
        logic wen;
        logic wide;
        logic [IRF_AW-1:0] idx;
        logic [IRF_FLEN-1:0] data;
    } irf_fp_req_t;
endpackage : irf_pkg

/* irf_regfile.sv */
// Integer, product and floating-point register storage with bypass
`timescale 1ns/1ps
`default_nettype none
module irf_regfile
    import irf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire irf_rd_req_t rd_a,
    input wire irf_rd_req_t rd_b,
    input wire irf_wr_t fwd_ex,
    input wire irf_wr_t fwd_mem,
    input wire irf_wr_t wb,
    input wire irf_prod_t prod_wr,
    input wire irf_fp_req_t fp_req,
    input wire logic fcsr_wen,
    input wire logic [IRF_FLEN-1:0] fcsr_wdata,
    output logic [IRF_XLEN-1:0] rd_a_data,
    output logic [IRF_XLEN-1:0] rd_b_data,
    output logic [IRF_XLEN-1:0] product_top_word,
    output logic [IRF_XLEN-1:0] product_bottom_word,
    output logic [IRF_FLEN-1:0] fp_rdata,
    output logic [IRF_FLEN-1:0] fcsr,
    output logic fp_trap
);
    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    logic [IRF_XLEN-1:0] gpr_reg [IRF_NREG];
    logic [IRF_XLEN-1:0] gpr_next [IRF_NREG];

    // Youngest producer wins; index zero never matches
    function automatic logic [IRF_XLEN-1:0] irf_pick(
        input logic [IRF_AW-1:0] idx,
        input irf_wr_t ex,
        input irf_wr_t mem,
        input irf_wr_t w,
        input logic [IRF_XLEN-1:0] stored
    );
        logic [IRF_XLEN-1:0] v;
        v = stored;
        if (idx == IRF_ZERO_IDX) begin
            v = IRF_RST_VAL;
        end else if (ex.en && ex.idx == idx) begin
            v = ex.data;
        end else if (mem.en && mem.idx == idx) begin
            v = mem.data;
        end else if (w.en && w.idx == idx) begin
            v = w.data;
        end
        return v;
    endfunction : irf_pick

    // ------------------------------------------------------------
    // General registers
    // ------------------------------------------------------------
    logic [IRF_XLEN-1:0] rd_a_next;
    logic [IRF_XLEN-1:0] rd_b_next;

    always_comb begin
        for (int i = 0; i < IRF_NREG; i++) begin
            gpr_next[i] = gpr_reg[i];
        end
        // One write port; slot zero stays constant
        if (wb.en && wb.idx != IRF_ZERO_IDX) begin
            gpr_next[wb.idx] = wb.data;
        end
        // Operands registered for the next stage
        rd_a_next = irf_pick(rd_a.idx, fwd_ex, fwd_mem, wb,
            gpr_reg[rd_a.idx]);
        rd_b_next = irf_pick(rd_b.idx, fwd_ex, fwd_mem, wb,
            gpr_reg[rd_b.idx]);
    end

    genvar g;
    generate
        for (g = 0; g < IRF_NREG; g++) begin : g_gpr
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    gpr_reg[g] <= IRF_RST_VAL;
                end else begin
                    gpr_reg[g] <= gpr_next[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_a_data <= IRF_RST_VAL;
            rd_b_data <= IRF_RST_VAL;
        end else begin
            rd_a_data <= rd_a_next;
            rd_b_data <= rd_b_next;
        end
    end

    // ------------------------------------------------------------
    // Product registers
    // ------------------------------------------------------------
    logic [IRF_XLEN-1:0] prod_top_next;
    logic [IRF_XLEN-1:0] prod_bot_next;

    always_comb begin
        prod_top_next = product_top_word;
        prod_bot_next = product_bottom_word;
        if (prod_wr.en) begin
            prod_top_next = prod_wr.top;
            prod_bot_next = prod_wr.bottom;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            product_top_word <= IRF_RST_VAL;
            product_bottom_word <= IRF_RST_VAL;
        end else begin
            product_top_word <= prod_top_next;
            product_bottom_word <= prod_bot_next;
        end
    end

    // ------------------------------------------------------------
    // Floating-point registers
    // ------------------------------------------------------------
    logic [IRF_FLEN-1:0] fpr_reg [IRF_NREG];
    logic [IRF_FLEN-1:0] fpr_next [IRF_NREG];
    logic [IRF_FLEN-1:0] fp_rdata_next;
    logic [IRF_FLEN-1:0] fcsr_next;
    logic fp_trap_next;

    always_comb begin
        for (int i = 0; i < IRF_NREG; i++) begin
            fpr_next[i] = fpr_reg[i];
        end
        fcsr_next = fcsr_wen ? fcsr_wdata : fcsr;
        // Wide access is refused: no write, data forced to zero
        fp_trap_next = fp_req.wide;
        fp_rdata_next = fp_req.wide ? IRF_FRST_VAL : fpr_reg[fp_req.idx];
        if (fp_req.wen && !fp_req.wide) begin
            fpr_next[fp_req.idx] = fp_req.data;
        end
    end

    generate
        for (g = 0; g < IRF_NREG; g++) begin : g_fpr
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    fpr_reg[g] <= IRF_FRST_VAL;
                end else begin
                    fpr_reg[g] <= fpr_next[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fp_rdata <= IRF_FRST_VAL;
            fcsr <= IRF_FCSR_RST;
            fp_trap <= 1'b0;
        end else begin
            fp_rdata <= fp_rdata_next;
            fcsr <= fcsr_next;
            fp_trap <= fp_trap_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_ZERO_A: assert property (@(posedge clk) disable iff (rst)
        rd_a.idx == IRF_ZERO_IDX |=> rd_a_data == IRF_RST_VAL)
        else $error("port A read of zero not zero");
    AST_ZERO_B: assert property (@(posedge clk) disable iff (rst)
        rd_b.idx == IRF_ZERO_IDX |=> rd_b_data == IRF_RST_VAL)
        else $error("port B read of zero not zero");
    AST_BYP_EX: assert property (@(posedge clk) disable iff (rst)
        fwd_ex.en && fwd_ex.idx == rd_a.idx && rd_a.idx != IRF_ZERO_IDX
        |=> rd_a_data == $past(fwd_ex.data))
        else $error("execute result not forwarded to port A");
    AST_BYP_MEM: assert property (@(posedge clk) disable iff (rst)
        fwd_mem.en && !(fwd_ex.en && fwd_ex.idx == rd_b.idx)
        && fwd_mem.idx == rd_b.idx && rd_b.idx != IRF_ZERO_IDX
        |=> rd_b_data == $past(fwd_mem.data))
        else $error("memory result not forwarded to port B");
    AST_WB_READ: assert property (@(posedge clk) disable iff (rst)
        wb.en && wb.idx != IRF_ZERO_IDX ##1 rd_a.idx == $past(wb.idx)
        && !fwd_ex.en && !fwd_mem.en && !wb.en
        |=> rd_a_data == $past(wb.data, 2))
        else $error("write-back value not stored");
    AST_GPR0: assert property (@(posedge clk) disable iff (rst)
        gpr_reg[0] == IRF_RST_VAL)
        else $error("register zero changed");
    AST_PROD: assert property (@(posedge clk) disable iff (rst)
        prod_wr.en |=> product_top_word == $past(prod_wr.top)
        && product_bottom_word == $past(prod_wr.bottom))
        else $error("product registers not loaded");
    AST_PROD_HOLD: assert property (@(posedge clk) disable iff (rst)
        !prod_wr.en |=> $stable(product_top_word))
        else $error("product top changed without write");
    AST_FP_TRAP: assert property (@(posedge clk) disable iff (rst)
        fp_req.wide |=> fp_trap && fp_rdata == IRF_FRST_VAL)
        else $error("wide FP reference did not trap");
    AST_FP_NOWR: assert property (@(posedge clk) disable iff (rst)
        fp_req.wen && fp_req.wide
        |=> fpr_reg[$past(fp_req.idx)] == $past(fpr_reg[fp_req.idx]))
        else $error("wide FP write changed a register");
    AST_FCSR: assert property (@(posedge clk) disable iff (rst)
        fcsr_wen |=> fcsr == $past(fcsr_wdata))
        else $error("FP control/status not written");
    AST_DUAL: assert property (@(posedge clk) disable iff (rst)
        rd_a.idx == rd_b.idx |=> rd_a_data == rd_b_data)
        else $error("two ports disagree on one index");
endmodule : irf_regfile
`default_nettype wire

/* irf_pipe_model.sv */
// Partner model: pipeline stages carrying results towards write-back
`timescale 1ns/1ps
`default_nettype none
module irf_pipe_model
    import irf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire irf_wr_t ex_in,
    output var irf_wr_t mem_out,
    output var irf_wr_t wb_out
);
    // ------------------------------------------------------------
    // Results age one stage a cycle, moved off the sampling edge
    // ------------------------------------------------------------
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            mem_out <= '0;
            wb_out <= '0;
        end else begin
            mem_out <= ex_in;
            wb_out <= mem_out;
        end
    end
endmodule : irf_pipe_model
`default_nettype wire

/* tb_irf.sv */
// Testbench: random pipeline traffic against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irf_pkg::*;
    logic clk, rst, fcsr_wen, fp_trap, e_trap;
    irf_rd_req_t rd_a, rd_b;
    irf_wr_t fwd_ex, fwd_mem, wb;
    irf_prod_t prod_wr;
    irf_fp_req_t fp_req;
    logic [31:0] fcsr_wdata, seed, r, fp_rdata, fcsr, e_fp, e_fcsr;
    logic [31:0] fpm [32];
    logic [63:0] rd_a_data, rd_b_data, p_top, p_bot, e_a, e_b, e_top, e_bot;
    logic [63:0] gm [32];
    int miscompares, num_checks;

    irf_regfile dut_u (.clk(clk), .rst(rst), .rd_a(rd_a), .rd_b(rd_b),
        .fwd_ex(fwd_ex), .fwd_mem(fwd_mem), .wb(wb), .prod_wr(prod_wr),
        .fp_req(fp_req), .fcsr_wen(fcsr_wen), .fcsr_wdata(fcsr_wdata),
        .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
        .product_top_word(p_top), .product_bottom_word(p_bot),
        .fp_rdata(fp_rdata), .fcsr(fcsr), .fp_trap(fp_trap));
    irf_pipe_model pipe_u (.clk(clk), .rst(rst), .ex_in(fwd_ex),
        .mem_out(fwd_mem), .wb_out(wb));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Youngest matching stage wins, index zero never forwards
    function automatic logic [63:0] pick(input logic [4:0] i);
        if (i == IRF_ZERO_IDX) return '0;
        if (fwd_ex.en && fwd_ex.idx == i) return fwd_ex.data;
        if (fwd_mem.en && fwd_mem.idx == i) return fwd_mem.data;
        if (wb.en && wb.idx == i) return wb.data;
        return gm[i];
    endfunction : pick

    task automatic clr();
        {e_a, e_b, e_top, e_bot, e_fp, e_fcsr, e_trap} = '0;
        for (int k = 0; k < 32; k++) begin
            gm[k] = '0;
            fpm[k] = '0;
        end
    endtask : clr

    task automatic chk(input string nm, input logic [63:0] e, g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_w(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk_w

    task automatic chk_f(input string nm, input logic e, g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %b got %b", nm, e, g);
        end
    endtask : chk_f

    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    // 2000 cycles of 50 ns expected, cut at three times that
    initial begin
        #300000;
        miscompares++;
        final_report();
    end

    initial begin
        seed = 32'h306B3C5B;
        rst = 1;
        {rd_a, rd_b, fwd_ex, prod_wr, fp_req, fcsr_wen, fcsr_wdata} = '0;
        clr();
        repeat (10) @(negedge clk);
        rst <= 0;
        for (int n = 0; n < 2000; n++) begin
            @(negedge clk);
            chk("rd_a_data", e_a, rd_a_data);
            chk("rd_b_data", e_b, rd_b_data);
            chk("product_top_word", e_top, p_top);
            chk("product_bottom_word", e_bot, p_bot);
            chk_w("fp_rdata", e_fp, fp_rdata);
            chk_w("fcsr", e_fcsr, fcsr);
            chk_f("fp_trap", e_trap, fp_trap);
            r = xs();
            // Occasional reset in mid-run
            rst <= (n % 700) == 699;
            rd_a.idx <= r[4:0];
            rd_b.idx <= r[9:5];
            fwd_ex <= {r[10], r[15:11], xs(), xs()};
            prod_wr <= {r[16], xs(), xs(), xs(), xs()};
            fp_req <= {r[17], r[21:18] == 4'h0, r[26:22], xs()};
            fcsr_wen <= r[27];
            fcsr_wdata <= xs();
            #1;
            if (rst) begin
                clr();
            end else begin
                e_a = pick(rd_a.idx);
                e_b = pick(rd_b.idx);
                if (prod_wr.en) {e_top, e_bot} = {prod_wr.top, prod_wr.bottom};
                e_trap = fp_req.wide;
                e_fp = fp_req.wide ? '0 : fpm[fp_req.idx];
                if (fp_req.wen && !fp_req.wide) fpm[fp_req.idx] = fp_req.data;
                if (fcsr_wen) e_fcsr = fcsr_wdata;
                if (wb.en && wb.idx != IRF_ZERO_IDX) begin
                    gm[wb.idx] = wb.data;
                end
            end
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
